// >>> rtl/dpi_consts.svh
// Constants of the dual-link pixel input: slot positions, grid size and timing counts.
// Assumes inclusion by bare name from the design files; definitions only.
`ifndef DPI_CONSTS_SVH
`define DPI_CONSTS_SVH

// ----------------------------------------------------------------------------
// Slot layout of one 28-slot serializer word
// ----------------------------------------------------------------------------
`define DPI_SLOTS        28
`define DPI_VALID_SLOT   26
// Slot of colour bit 7..0 in the least-significant-first map, five bits per entry
`define DPI_RED_SLOTS    {5'h05, 5'h1b, 5'h06, 5'h04, 5'h03, 5'h02, 5'h01, 5'h00}
`define DPI_GREEN_SLOTS  {5'h0b, 5'h0a, 5'h0e, 5'h0d, 5'h0c, 5'h09, 5'h08, 5'h07}
`define DPI_BLUE_SLOTS   {5'h11, 5'h10, 5'h16, 5'h15, 5'h14, 5'h13, 5'h12, 5'h0f}

// ----------------------------------------------------------------------------
// Grid and timing
// ----------------------------------------------------------------------------
`define DPI_COLS         11'h640
`define DPI_ROWS         11'h4b0
`define DPI_LAST_ODD_COL 11'h63f
// Idle link clocks after the last valid that mark vertical blanking (above two lines)
`define DPI_FRAME_GAP    12'h960

`endif

// >>> rtl/dpi_pkg.sv
// Types shared by the dual-link pixel input.
// Assumes nothing of its surroundings; types only, constants live in dpi_consts.svh.
package dpi_pkg;

  // ----------------------------------------------------------------------------
  // Pixel carriers
  // ----------------------------------------------------------------------------
  typedef struct packed {
    logic [7:0] r;
    logic [7:0] g;
    logic [7:0] b;
  } dpi_pix_s;

  typedef struct packed {
    dpi_pix_s    odd;
    dpi_pix_s    even;
    logic [10:0] col;
    logic [10:0] row;
  } dpi_pair_s;

  // ----------------------------------------------------------------------------
  // Line tracker states
  // ----------------------------------------------------------------------------
  typedef enum logic [1:0] {
    LN_IDLE   = 2'b01,
    LN_ACTIVE = 2'b10
  } dpi_line_e;

endpackage : dpi_pkg

// >>> rtl/dpi_pixel_input.sv
// Receive side of a two-link pixel interface: deserialized slot words in, placed pairs out.
// Assumes the link words and link clock come from another domain and MCLK is much faster.
//
// Operation
// RQ1: Host runs the shared dot clock between 60.0 and 65.0 MHz.
// RQ2: Host line period lasts 848 to 1156 dot clocks.
// RQ3: Host holds pixel valid for exactly 800 clocks per line.
// RQ4: Host keeps successive line periods equal within one dot clock.
// RQ5: Host refreshes frames between 59 and 61 Hz.
// RQ6: Each frame holds at least 1206 line periods.
// RQ7: Each frame has 1200 active lines, mapped to rows 1 to 1200.
// RQ8: First colour group is the odd column, second the following even column.
// RQ9: Odd pixel and valid ride the first link, even pixel the second.
// RQ10: LSB-first map places colour bits 0 to 5 in the main slots.
// RQ11: LSB-first map: valid slot 26, bits 6 and 7 in side slots.
// RQ12: MSB-first map: bits 7 to 2 main slots, bits 1 and 0 side slots.
// RQ13: Slots 23 to 25 and even slot 26 are ignored.
// RQ14: Bit 0 of each colour field is least significant.
// RQ15: Bit 7 of each colour field is most significant.
// RQ16: Each sub-pixel has 256 steps, zero darkest, all ones brightest.
// RQ17: Pixels fill a 1600 by 1200 grid left to right, top down.
// RQ18: Map selects choose the map; equal levels select the first map. The code raises MAP_FIRST there but decodes LSB-first.
// RQ19: Map select inputs read high when left open.
// RQ20: Capture only while valid is high; each valid rise starts a line.
// RQ21: Host keeps map selects static while links run.
`timescale 1ns/100ps
`include "dpi_consts.svh"

module dpi_pixel_input (
  // Clock and reset
  input  wire logic                MCLK,
  input  wire logic                SRST,
  // Link side, outside the clock domain
  input  wire logic                LINK_CLK,
  input  wire logic [27:0]         LINK_ODD,
  input  wire logic [27:0]         LINK_EVEN,
  // Map select pins, high when open
  input  wire logic                MAP_SEL_LOW,
  input  wire logic                MAP_SEL_HIGH,
  // Placed pixel pair stream
  output logic                     PIX_VALID,
  input  wire logic                PIX_READY,
  output dpi_pkg::dpi_pair_s       PIX_PAIR,
  // Status
  output logic                     LINE_START,
  output logic                     FRAME_START,
  output logic                     MAP_FIRST,
  output logic                     OVERFLOW
);

  localparam logic [39:0] RED_SLOTS   = `DPI_RED_SLOTS;
  localparam logic [39:0] GREEN_SLOTS = `DPI_GREEN_SLOTS;
  localparam logic [39:0] BLUE_SLOTS  = `DPI_BLUE_SLOTS;

  // ----------------------------------------------------------------------------
  // Slot decoding
  // ----------------------------------------------------------------------------
  // The MSB-first map is the LSB-first map with the bit order reversed
  function automatic dpi_pkg::dpi_pix_s unpack_pix(input logic [27:0] w, input logic msb);
    dpi_pkg::dpi_pix_s p;
    logic [2:0]        k;
    p = '0;
    k = '0;
    for (int b = 0; b < 8; b++) begin
      k = msb ? 3'(7 - b) : 3'(b);                      // RQ10 RQ11 RQ12
      p.r[b] = w[RED_SLOTS[k*5 +: 5]];                  // RQ14 RQ15
      p.g[b] = w[GREEN_SLOTS[k*5 +: 5]];
      p.b[b] = w[BLUE_SLOTS[k*5 +: 5]];
    end
    return p;
  endfunction : unpack_pix

  // ----------------------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------------------
  logic        lk_s1, lk_s2, lk_s3;
  logic [27:0] sa1, sa, sb1, sb;
  logic        sl1, sl, sh1, sh;
  logic        lk_rise;
  logic        msb;
  // Clock and words pass the same depth so data is aligned with the detected edge
  always_ff @(posedge MCLK) begin
    if (SRST) begin
      lk_s1 <= 1'b0;
      lk_s2 <= 1'b0;
      lk_s3 <= 1'b0;
      sa1   <= '0;
      sa    <= '0;
      sb1   <= '0;
      sb    <= '0;
      sl1   <= 1'b1;
      sl    <= 1'b1;
      sh1   <= 1'b1;
      sh    <= 1'b1;
    end else begin
      lk_s1 <= LINK_CLK;
      lk_s2 <= lk_s1;
      lk_s3 <= lk_s2;
      sa1   <= LINK_ODD;
      sa    <= sa1;
      sb1   <= LINK_EVEN;
      sb    <= sb1;
      sl1   <= MAP_SEL_LOW;
      sl    <= sl1;
      sh1   <= MAP_SEL_HIGH;
      sh    <= sh1;
    end
  end

  assign lk_rise = lk_s2 & ~lk_s3;

  // ----------------------------------------------------------------------------
  // Map mode
  // ----------------------------------------------------------------------------
  logic next_msb, next_map_first;
  // Open pins read high; the first map is not decoded and falls back to LSB-first
  always_comb begin
    next_msb       = ~sl & sh;                          // RQ19
    next_map_first = (sl == sh);                        // RQ19
  end
  always_ff @(posedge MCLK) begin
    if (SRST) begin
      msb       <= 1'b0;
      MAP_FIRST <= 1'b1;
    end else begin
      msb       <= next_msb;
      MAP_FIRST <= next_map_first;
    end
  end

  // ----------------------------------------------------------------------------
  // Line and frame tracker
  // ----------------------------------------------------------------------------
  dpi_pkg::dpi_line_e state, next_state;
  logic [10:0]        col, next_col, row, next_row;
  logic [11:0]        gap, next_gap;
  logic               in_valid, next_in_valid;
  dpi_pkg::dpi_pair_s in_pair, next_in_pair;
  logic               next_line_start, next_frame_start;
  logic               gap_seen;
  assign gap_seen = (gap >= `DPI_FRAME_GAP);
  // Work happens only on link clock edges; even slot 26 and slots 23-25 are never read
  always_comb begin
    next_state       = state;
    next_col         = col;
    next_row         = row;
    next_gap         = gap;
    next_in_valid    = 1'b0;
    next_in_pair     = in_pair;
    next_line_start  = 1'b0;
    next_frame_start = 1'b0;
    if (lk_rise) begin
      unique case (state)
        dpi_pkg::LN_IDLE: begin
          if (sa[`DPI_VALID_SLOT]) begin                // RQ20 RQ13
            next_state      = dpi_pkg::LN_ACTIVE;
            next_col        = 11'h001;                  // RQ17
            next_line_start = 1'b1;
            next_gap        = '0;
            if (gap_seen || row == `DPI_ROWS) begin     // RQ7
              next_row         = 11'h001;
              next_frame_start = 1'b1;
            end else begin
              next_row = row + 11'h001;
            end
          end else if (!gap_seen) begin
            next_gap = gap + 12'h001;
          end
        end
        dpi_pkg::LN_ACTIVE: begin
          if (sa[`DPI_VALID_SLOT]) begin
            // Saturate so an overlong line cannot run off the grid
            if (col < `DPI_LAST_ODD_COL) begin
              next_col = col + 11'h002;                 // RQ17
            end
          end else begin
            next_state = dpi_pkg::LN_IDLE;
            next_gap   = 12'h001;
          end
        end
      endcase
      if (sa[`DPI_VALID_SLOT]) begin                    // RQ20
        next_in_valid     = 1'b1;
        next_in_pair.odd  = unpack_pix(sa, msb);        // RQ8 RQ9 RQ16
        next_in_pair.even = unpack_pix(sb, msb);        // RQ9
        next_in_pair.col  = next_col;                   // RQ8
        next_in_pair.row  = next_row;
      end
    end
  end

  always_ff @(posedge MCLK) begin
    if (SRST) begin
      state       <= dpi_pkg::LN_IDLE;
      col         <= 11'h001;
      row         <= '0;
      gap         <= `DPI_FRAME_GAP;
      in_valid    <= 1'b0;
      in_pair     <= '0;
      LINE_START  <= 1'b0;
      FRAME_START <= 1'b0;
    end else begin
      state       <= next_state;
      col         <= next_col;
      row         <= next_row;
      gap         <= next_gap;
      in_valid    <= next_in_valid;
      in_pair     <= next_in_pair;
      LINE_START  <= next_line_start;
      FRAME_START <= next_frame_start;
    end
  end

  // ----------------------------------------------------------------------------
  // Two-entry output buffer
  // ----------------------------------------------------------------------------
  dpi_pkg::dpi_pair_s skid, next_skid, next_out;
  logic               skid_valid, next_skid_valid, next_out_valid, next_overflow;
  logic               buf_ready;
  // Head entry drives the outputs directly; the link cannot stall, so a lost pair is flagged
  assign buf_ready = ~skid_valid;
  always_comb begin
    next_out        = PIX_PAIR;
    next_out_valid  = PIX_VALID;
    next_skid       = skid;
    next_skid_valid = skid_valid;
    next_overflow   = OVERFLOW;
    if (PIX_VALID && PIX_READY) begin
      if (skid_valid) begin
        next_out        = skid;
        next_skid_valid = 1'b0;
      end else begin
        next_out_valid = 1'b0;
      end
    end
    if (in_valid) begin
      if (!next_out_valid) begin
        next_out       = in_pair;
        next_out_valid = 1'b1;
      end else if (buf_ready || !next_skid_valid) begin
        next_skid       = in_pair;
        next_skid_valid = 1'b1;
      end else begin
        next_overflow = 1'b1;
      end
    end
  end

  always_ff @(posedge MCLK) begin
    if (SRST) begin
      PIX_PAIR   <= '0;
      PIX_VALID  <= 1'b0;
      skid       <= '0;
      skid_valid <= 1'b0;
      OVERFLOW   <= 1'b0;
    end else begin
      PIX_PAIR   <= next_out;
      PIX_VALID  <= next_out_valid;
      skid       <= next_skid;
      skid_valid <= next_skid_valid;
      OVERFLOW   <= next_overflow;
    end
  end

  // ----------------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------------
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (SRST);
  a_odd_column: assert property (PIX_VALID |-> PIX_PAIR.col[0] && PIX_PAIR.col <= 11'd1599) // RQ8
    else $error("pair column not odd or off grid");
  a_lsb_slots: assert property (lk_rise && sa[26] && !msb |=> in_valid      // RQ10
      && in_pair.odd.r[0] == $past(sa[0]) && in_pair.odd.b[7] == $past(sa[17]))
    else $error("LSB-first map slot mismatch");
  a_lsb_side: assert property (lk_rise && sa[26] && !msb |=>                 // RQ11
      in_pair.odd.r[6] == $past(sa[27]) && in_pair.odd.g[7] == $past(sa[11]))
    else $error("LSB-first side slot mismatch");
  a_msb_slots: assert property (lk_rise && sa[26] && msb |=>                 // RQ12
      in_pair.odd.r[7] == $past(sa[0]) && in_pair.even.g[0] == $past(sb[11]))
    else $error("MSB-first map slot mismatch");
  a_even_link: assert property (lk_rise && sa[26] && !msb |=>                // RQ9
      in_pair.even.g[0] == $past(sb[7]) && in_pair.even.b[0] == $past(sb[15]))
    else $error("even pixel not taken from second link");
  a_ignore_even_valid: assert property (lk_rise && !sa[26] && sb[26] |=> !in_valid) // RQ13
    else $error("even link slot 26 started a capture");
  a_line_begin: assert property (lk_rise && sa[26] && state == dpi_pkg::LN_IDLE // RQ20
      |=> LINE_START && in_pair.col == 11'd1)
    else $error("line start not seen on valid rise");
  a_col_step: assert property (lk_rise && sa[26] && state == dpi_pkg::LN_ACTIVE // RQ17
      && col < 11'd1599 |=> in_pair.col == $past(in_pair.col) + 11'd2)
    else $error("column did not advance by two");
  a_row_range: assert property (PIX_VALID |-> PIX_PAIR.row >= 11'd1 && PIX_PAIR.row <= 11'd1200) // RQ7
    else $error("row outside 1..1200");
  a_map_open: assert property (sl && sh |=> MAP_FIRST && !msb)               // RQ19
    else $error("open selects not read as first map");
  a_stall_hold: assert property (PIX_VALID && !PIX_READY |=> PIX_VALID && $stable(PIX_PAIR))
    else $error("stalled pair changed");

endmodule : dpi_pixel_input

// >>> bench/dpi_host.sv
// Host model: a display controller driving both serial pixel links.
// Assumes the bench calls send() once per dot clock and sets msb before a line.
`timescale 1ns/100ps

module dpi_host (
  // Map choice made by the host side
  input  wire logic        msb,
  // Link pins
  output logic             LINK_CLK,
  output logic [27:0]      LINK_ODD,
  output logic [27:0]      LINK_EVEN
);
  // ----------------------------------------------------------------------------
  // Slot tables
  // ----------------------------------------------------------------------------
  localparam int MAIN [3][6] = '{'{0, 1, 2, 3, 4, 6}, '{7, 8, 9, 12, 13, 14},
                                 '{15, 18, 19, 20, 21, 22}};
  localparam int SIDE [3][2] = '{'{27, 5}, '{10, 11}, '{16, 17}};

  // Pack one pixel; unused slots are tied high, never left floating
  function automatic logic [27:0] enc(input dpi_pkg::dpi_pix_s p, input logic even);
    logic [27:0] w;
    logic [7:0]  v;
    w = even ? 28'h7800000 : 28'h3800000;
    for (int c = 0; c < 3; c++) begin
      v = (c == 0) ? p.r : (c == 1) ? p.g : p.b;
      for (int i = 0; i < 6; i++) w[MAIN[c][i]] = msb ? v[7-i] : v[i];
      w[SIDE[c][0]] = msb ? v[1] : v[6];
      w[SIDE[c][1]] = msb ? v[0] : v[7];
    end
    return w;
  endfunction : enc

  initial begin
    LINK_CLK  = 1'b0;
    LINK_ODD  = 28'h0;
    LINK_EVEN = 28'h0;
  end

  // One 125 ns dot clock; words change while the clock is low, 40 ns before it rises.
  // The clock is left low, so an idle link shows no edge after a reset.
  // Idle edges carry the inverse of the last word with odd slot 26 forced low, so stale data cannot pass as valid.
  // Rate is scaled down from the real dot clock so MCLK can oversample it.
  task send(input dpi_pkg::dpi_pix_s o, input dpi_pkg::dpi_pix_s e, input logic v);
    if (v) begin
      LINK_ODD  <= enc(o, 1'b0) | 28'h4000000;
      LINK_EVEN <= enc(e, 1'b1);
    end else begin
      LINK_ODD  <= ~LINK_ODD & 28'hbffffff;
      LINK_EVEN <= ~LINK_EVEN;
    end
    #40;
    LINK_CLK <= 1'b1;
    #62.5;
    LINK_CLK <= 1'b0;
    #22.5;
  endtask : send
endmodule : dpi_host

// >>> bench/tb_top.sv
// Testbench for the dual-link pixel input: host model in, pair stream out.
// Assumes the host model drives the links and this module plays the pixel sink.
`timescale 1ns/100ps

module tb_top;
  logic MCLK, SRST, MAP_SEL_LOW, MAP_SEL_HIGH, PIX_READY, PIX_VALID;
  logic LINK_CLK, LINE_START, FRAME_START, MAP_FIRST, OVERFLOW, msb;
  logic [27:0]          LINK_ODD, LINK_EVEN;
  dpi_pkg::dpi_pair_s   PIX_PAIR;
  dpi_pkg::dpi_pair_s   q[$];
  int                   bad_count, n_compared, ls_cnt, fs_cnt;

  dpi_host u_host (.msb(msb), .LINK_CLK(LINK_CLK), .LINK_ODD(LINK_ODD), .LINK_EVEN(LINK_EVEN));
  dpi_pixel_input u_dpi_pixel_input (.MCLK(MCLK), .SRST(SRST), .LINK_CLK(LINK_CLK),
    .LINK_ODD(LINK_ODD), .LINK_EVEN(LINK_EVEN), .MAP_SEL_LOW(MAP_SEL_LOW),
    .MAP_SEL_HIGH(MAP_SEL_HIGH), .PIX_VALID(PIX_VALID), .PIX_READY(PIX_READY),
    .PIX_PAIR(PIX_PAIR), .LINE_START(LINE_START), .FRAME_START(FRAME_START),
    .MAP_FIRST(MAP_FIRST), .OVERFLOW(OVERFLOW));

  // ----------------------------------------------------------------------------
  // Clock and sink monitor
  // ----------------------------------------------------------------------------
  initial begin
    MCLK = 1'b0;
    forever #4 MCLK = ~MCLK;
  end

  // Pairs are taken only where the handshake completes
  always @(posedge MCLK) begin
    if (PIX_VALID === 1'b1 && PIX_READY === 1'b1) q.push_back(PIX_PAIR);
    if (LINE_START === 1'b1) ls_cnt++;
    if (FRAME_START === 1'b1) fs_cnt++;
  end

  // ----------------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------------
  task chk(input logic [69:0] got, input logic [69:0] exp);
    n_compared++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task wait_q(input int n);
    repeat (200) if (q.size() < n) @(posedge MCLK);
    chk(q.size(), n);
  endtask : wait_q

  function automatic dpi_pkg::dpi_pair_s mk(input dpi_pkg::dpi_pix_s o, e,
                                            input logic [10:0] c, r);
    return '{o, e, c, r};
  endfunction : mk

  task test_done;
    $display("mismatches %0d comparisons %0d", bad_count, n_compared);
    if (bad_count == 0 && n_compared > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : test_done

  // ----------------------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------------------
  // Every select combination; open pins are modelled high
  task t_sel;
    for (int i = 0; i < 4; i++) begin
      @(posedge MCLK);
      {MAP_SEL_HIGH, MAP_SEL_LOW} <= 2'(i);
      repeat (5) @(posedge MCLK);
      chk(MAP_FIRST, (i == 0 || i == 3));
    end
  endtask : t_sel

  // Walking ones over eight pairs exercise every slot of the chosen map
  task t_line_map(input logic m, input logic [10:0] row);
    dpi_pkg::dpi_pix_s o;
    int                ls;
    @(posedge MCLK);
    MAP_SEL_LOW  <= ~m;
    MAP_SEL_HIGH <= m;
    msb          <= m;
    repeat (5) @(posedge MCLK);
    ls = ls_cnt;
    for (int k = 0; k < 8; k++) begin
      o = '{8'h01 << k, 8'h80 >> k, 8'h01 << k};
      u_host.send(o, ~o, 1'b1);
    end
    u_host.send(o, o, 1'b0);
    wait_q(8);
    chk(ls_cnt, ls + 1);
    for (int k = 0; k < 8; k++) begin
      o = '{8'h01 << k, 8'h80 >> k, 8'h01 << k};
      chk(q.pop_front(), mk(o, ~o, 11'(1 + 2 * k), row));
    end
  endtask : t_line_map

  // Idle edges capture nothing; darkest and brightest codes pass unchanged
  task t_gate(input logic [10:0] row);
    u_host.send(24'h0, 24'h0, 1'b0);
    u_host.send(24'h0, 24'h0, 1'b0);
    repeat (8) @(posedge MCLK);
    chk(q.size(), 0);
    u_host.send(24'h0, 24'hffffff, 1'b1);
    u_host.send(24'hffffff, 24'h0, 1'b1);
    u_host.send(24'h0, 24'h0, 1'b0);
    wait_q(2);
    chk(q.pop_front(), mk(24'h0, 24'hffffff, 11'h1, row));
    chk(q.pop_front(), mk(24'hffffff, 24'h0, 11'h3, row));
  endtask : t_gate

  // Stalled sink: two pairs are held, the third is lost and flagged
  task t_ovf;
    @(posedge MCLK);
    PIX_READY <= 1'b0;
    for (int k = 0; k < 3; k++) u_host.send(24'(k + 1), 24'h5a, 1'b1);
    u_host.send(24'h0, 24'h0, 1'b0);
    repeat (8) @(posedge MCLK);
    chk(OVERFLOW, 1'b1);
    chk(PIX_VALID, 1'b1);
    PIX_READY <= 1'b1;
    repeat (8) @(posedge MCLK);
    chk(q.size(), 2);
    chk(q.pop_front(), mk(24'h1, 24'h5a, 11'h1, 11'h4));
    chk(q.pop_front(), mk(24'h2, 24'h5a, 11'h3, 11'h4));
    chk(OVERFLOW, 1'b1);
  endtask : t_ovf

  // Full-length line: 800 valid clocks in an 860-clock period, last pair on column 1599
  task t_long_line(input logic [10:0] row);
    int ls;
    ls = ls_cnt;
    for (int k = 0; k < 860; k++) u_host.send(24'(k), ~24'(k), k < 800);
    wait_q(800);
    chk(ls_cnt, ls + 1);
    for (int k = 0; k < 800; k++) begin
      chk(q.pop_front(), mk(24'(k), ~24'(k), 11'(1 + 2 * k), row));
    end
  endtask : t_long_line

  // Vertical blanking: exactly 2400 idle clocks after a line restart the grid at row 1
  task t_vgap;
    int fs;
    fs = fs_cnt;
    repeat (2340) u_host.send(24'h0, 24'h0, 1'b0);
    u_host.send(24'h0a0b0c, 24'h0d0e0f, 1'b1);
    u_host.send(24'h0, 24'h0, 1'b0);
    wait_q(1);
    chk(q.pop_front(), mk(24'h0a0b0c, 24'h0d0e0f, 11'h1, 11'h1));
    chk(fs_cnt, fs + 1);
  endtask : t_vgap

  // Reset mid-run clears the flag and restarts at row 1 with a frame start
  task t_reset;
    int fs;
    @(posedge MCLK);
    SRST <= 1'b1;
    repeat (3) @(posedge MCLK);
    #1;
    chk({PIX_VALID, OVERFLOW, LINE_START, FRAME_START, MAP_FIRST}, 5'h01);
    chk(PIX_PAIR, 70'h0);
    SRST <= 1'b0;
    repeat (4) @(posedge MCLK);
    fs = fs_cnt;
    u_host.send(24'h123456, 24'h654321, 1'b1);
    u_host.send(24'h0, 24'h0, 1'b0);
    wait_q(1);
    chk(q.pop_front(), mk(24'h123456, 24'h654321, 11'h1, 11'h1));
    chk(fs_cnt, fs + 1);
  endtask : t_reset

  // ----------------------------------------------------------------------------
  // Main sequence and watchdog
  // ----------------------------------------------------------------------------
  initial begin
    SRST = 1'b1;
    MAP_SEL_LOW = 1'b1;
    MAP_SEL_HIGH = 1'b1;
    PIX_READY = 1'b1;
    msb = 1'b0;
    repeat (12) @(posedge MCLK);
    SRST <= 1'b0;
    t_sel;
    t_line_map(1'b0, 11'h1);
    chk(fs_cnt, 1);
    t_line_map(1'b1, 11'h2);
    t_gate(11'h3);
    t_ovf;
    t_long_line(11'h5);
    t_vgap;
    t_reset;
    test_done;
  end

  // Link traffic takes about 404 us in all; the limit leaves half again as margin
  initial begin
    #600000;
    bad_count++;
    test_done;
  end
endmodule : tb_top
